// >>> verilog/slms_defs.vh
// Register map, field positions, reset values and timing for the lane block
`ifndef SLMS_DEFS_VH
`define SLMS_DEFS_VH
`define SLMS_ADDR_W 12
`define SLMS_OFF_FULL 12'h30C
`define SLMS_OFF_EMPTY 12'h30D
`define SLMS_OFF_LOSS_EN 12'h311
`define SLMS_OFF_PULSE 12'h312
`define SLMS_OFF_PHY_TEST 12'h315
`define SLMS_OFF_LANE6 12'h30B
`define SLMS_RST_LANE6 3'h6
`define SLMS_RST_LOSS_EN 4'h0
`define SLMS_RST_PULSE 8'h00
`define SLMS_RST_PHY_TEST 8'h00
`define SLMS_BIT_EOF0 0
`define SLMS_BIT_EOF1 1
`define SLMS_BIT_EOMF0 2
`define SLMS_BIT_EOMF1 3
`define SLMS_CODE_HI 7
`define SLMS_CODE_LO 4
`define SLMS_PCLK_DIV 4
`endif

// >>> verilog/slms_sync_pulse.v
// Error-report pulse generator for one sync-request output
`timescale 1ns/1ps
module slms_sync_pulse #(
    parameter HALF = 2 // System cycles in half a PCLK cycle
) (
    input wire clk_in,
    input wire reset_in,
    input wire ce_in,
    input wire trigger_in, // One-cycle loss event
    input wire [3:0] code_in, // Shared pulse code
    output reg sync_n_out // Active low request
);
    // Low time is (2*code+1) half PCLK cycles
    reg [7:0] halves; // Remaining half periods
    reg [7:0] tick; // Cycles within half period

    // Retrigger restarts the count; pulse never shorter than code
    always @(posedge clk_in) begin
        if (reset_in) begin
            halves <= 8'h00;
            tick <= 8'h00;
            sync_n_out <= 1'b1;
        end else if (ce_in) begin
            if (trigger_in) begin
                halves <= {3'b000, code_in, 1'b1};
                tick <= 8'h00;
                sync_n_out <= 1'b0;
            end else if (halves != 8'h00) begin
                if (tick == HALF - 1) begin
                    tick <= 8'h00;
                    halves <= halves - 8'h01;
                    if (halves == 8'h01) begin
                        sync_n_out <= 1'b1;
                    end
                end else begin
                    tick <= tick + 8'h01;
                end
            end
        end
    end
endmodule // slms_sync_pulse

// >>> verilog/slms_lane_map_sync.v
// Lane six mapping, FIFO flags, sync-request generation and PHY test enable
// How it works
// - Code n routes physical lane n to six
// - Full flags, bit x for lane x
// - Empty flags, bit x for lane x
// - Multiframe loss enable gates output one
// - Multiframe loss enable gates output zero
// - Frame loss enable gates output one
// - Frame loss enable gates output zero
// - Low for half plus code PCLK cycles
// - One pulse code shared by both outputs
// - Eight-bit PHY test clock ungate, reset zero
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "slms_defs.vh"
module slms_lane_map_sync #(
    parameter LANES = 8, // Physical serial lanes
    parameter DATA_W = 32, // Lane word width
    parameter PCLK_DIV = `SLMS_PCLK_DIV // System cycles per PCLK
) (
    input wire CLK_IN,
    input wire RESET_IN,
    input wire CE_IN,
    input wire [`SLMS_ADDR_W-1:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [7:0] RDATA_OUT,
    input wire [LANES*DATA_W-1:0] LANE_DATA_IN, // Serial lane words
    input wire [LANES-1:0] FIFO_FULL_IN, // Per-lane FIFO full
    input wire [LANES-1:0] FIFO_EMPTY_IN, // Per-lane FIFO empty
    input wire [1:0] FRAME_LOSS_IN, // Frame loss per decoder
    input wire [1:0] MFRAME_LOSS_IN, // Multiframe loss per decoder
    output reg [DATA_W-1:0] LANE6_DATA_OUT, // Logical lane six
    output wire SYNC_N_0_OUT, // Sync request 0, low active
    output wire SYNC_N_1_OUT, // Sync request 1, low active
    output reg [7:0] PHY_CLK_UNGATE_OUT // PHY BER clock ungate
);
    // Control registers
    reg [2:0] lane_six_source_select; // Lane six source
    reg [3:0] loss_en; // Loss enables
    reg [7:0] pulse_reg; // Pulse code in high nibble
    // Pin synchronisers for asynchronous flags
    reg [LANES-1:0] full_s1;
    reg [LANES-1:0] full_s2;
    reg [LANES-1:0] empty_s1;
    reg [LANES-1:0] empty_s2;
    reg [1:0] fl_s1;
    reg [1:0] fl_s2;
    reg [1:0] fl_d;
    reg [1:0] ml_s1;
    reg [1:0] ml_s2;
    reg [1:0] ml_d;
    wire [3:0] error_report_pulse_code;
    wire [1:0] frame_rise;
    wire [1:0] mframe_rise;
    wire [1:0] trig;
    reg [DATA_W-1:0] next_lane6;
    reg [7:0] next_rdata;
    integer i;

    assign error_report_pulse_code =
        pulse_reg[`SLMS_CODE_HI:`SLMS_CODE_LO];
    assign frame_rise = fl_s2 & ~fl_d;
    assign mframe_rise = ml_s2 & ~ml_d;
    // Loss events gated by their enables
    assign trig[0] = (frame_rise[0] & loss_en[`SLMS_BIT_EOF0])
        | (mframe_rise[0] & loss_en[`SLMS_BIT_EOMF0]);
    assign trig[1] = (frame_rise[1] & loss_en[`SLMS_BIT_EOF1])
        | (mframe_rise[1] & loss_en[`SLMS_BIT_EOMF1]);

    // Two-stage synchronisers, then edge registers
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            full_s1 <= {LANES{1'b0}};
            full_s2 <= {LANES{1'b0}};
            empty_s1 <= {LANES{1'b0}};
            empty_s2 <= {LANES{1'b0}};
            fl_s1 <= 2'h0;
            fl_s2 <= 2'h0;
            fl_d <= 2'h0;
            ml_s1 <= 2'h0;
            ml_s2 <= 2'h0;
            ml_d <= 2'h0;
        end else if (CE_IN) begin
            full_s1 <= FIFO_FULL_IN;
            full_s2 <= full_s1;
            empty_s1 <= FIFO_EMPTY_IN;
            empty_s2 <= empty_s1;
            fl_s1 <= FRAME_LOSS_IN;
            fl_s2 <= fl_s1;
            fl_d <= fl_s2;
            ml_s1 <= MFRAME_LOSS_IN;
            ml_s2 <= ml_s1;
            ml_d <= ml_s2;
        end
    end

    // Lane six crossbar; out-of-range code falls back to lane 0
    always @* begin
        next_lane6 = LANE_DATA_IN[DATA_W-1:0];
        for (i = 0; i < LANES; i = i + 1) begin
            if (lane_six_source_select == i[2:0]) begin
                next_lane6 = LANE_DATA_IN[i*DATA_W +: DATA_W];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        next_rdata = 8'h00;
        case (ADDR_IN)
            `SLMS_OFF_FULL: begin
                next_rdata[LANES-1:0] = full_s2;
            end
            `SLMS_OFF_EMPTY: begin
                next_rdata[LANES-1:0] = empty_s2;
            end
            `SLMS_OFF_LOSS_EN: begin
                next_rdata = {4'h0, loss_en};
            end
            `SLMS_OFF_PULSE: begin
                next_rdata = pulse_reg;
            end
            `SLMS_OFF_PHY_TEST: begin
                next_rdata = PHY_CLK_UNGATE_OUT;
            end
            `SLMS_OFF_LANE6: begin
                next_rdata = {5'h00, lane_six_source_select};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Register writes, read data and lane output
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            lane_six_source_select <= `SLMS_RST_LANE6;
            loss_en <= `SLMS_RST_LOSS_EN;
            pulse_reg <= `SLMS_RST_PULSE;
            PHY_CLK_UNGATE_OUT <= `SLMS_RST_PHY_TEST;
            RDATA_OUT <= 8'h00;
            LANE6_DATA_OUT <= {DATA_W{1'b0}};
        end else if (CE_IN) begin
            LANE6_DATA_OUT <= next_lane6;
            // Read data valid only the cycle after the strobe
            RDATA_OUT <= RD_IN ? next_rdata : 8'h00;
            if (WR_IN) begin
                case (ADDR_IN)
                    `SLMS_OFF_LOSS_EN: begin
                        loss_en <= WDATA_IN[3:0]; // Top nibble reserved
                    end
                    `SLMS_OFF_PULSE: begin
                        pulse_reg <= WDATA_IN;
                    end
                    `SLMS_OFF_PHY_TEST: begin
                        PHY_CLK_UNGATE_OUT <= WDATA_IN;
                    end
                    `SLMS_OFF_LANE6: begin
                        lane_six_source_select <= WDATA_IN[2:0];
                    end
                    default: begin
                        loss_en <= loss_en; // Read-only or unmapped
                    end
                endcase
            end
        end
    end

    // Half a PCLK in system cycles
    localparam HALF_PCLK = (PCLK_DIV / 2 < 1) ? 1 : PCLK_DIV / 2;

    // One generator per output, sharing one code
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_sync
            wire sync_n;
            slms_sync_pulse #(
                .HALF(HALF_PCLK)
            ) u_pulse (
                .clk_in(CLK_IN),
                .reset_in(RESET_IN),
                .ce_in(CE_IN),
                .trigger_in(trig[g]),
                .code_in(error_report_pulse_code),
                .sync_n_out(sync_n)
            );
        end
    endgenerate
    assign SYNC_N_0_OUT = gen_sync[0].sync_n;
    assign SYNC_N_1_OUT = gen_sync[1].sync_n;
endmodule // slms_lane_map_sync

// >>> verification/slms_properties.sv
// Port assertions for the lane map and sync-request block
`timescale 1ns/1ps
`include "slms_defs.vh"
module slms_props #(
    parameter PCLK_DIV = 4
) (
    input wire CLK_IN,
    input wire RESET_IN,
    input wire [`SLMS_ADDR_W-1:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    input wire [7:0] RDATA_OUT,
    input wire [7:0] FIFO_FULL_IN,
    input wire [7:0] FIFO_EMPTY_IN,
    input wire [1:0] FRAME_LOSS_IN,
    input wire [1:0] MFRAME_LOSS_IN,
    input wire SYNC_N_0_OUT,
    input wire SYNC_N_1_OUT,
    input wire [7:0] PHY_CLK_UNGATE_OUT
);
    reg [3:0] en; // Loss enable shadow
    reg [3:0] code; // Pulse code shadow
    reg [7:0] lo0; // Low run, output 0
    reg [7:0] lo1; // Low run, output 1
    // Shadows of host writes; CE_IN is held high
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            en <= 4'h0;
            code <= 4'h0;
        end else if (WR_IN) begin
            if (ADDR_IN == `SLMS_OFF_LOSS_EN) en <= WDATA_IN[3:0];
            if (ADDR_IN == `SLMS_OFF_PULSE) code <= WDATA_IN[7:4];
        end
        lo0 <= SYNC_N_0_OUT ? 8'h00 : lo0 + 8'h01;
        lo1 <= SYNC_N_1_OUT ? 8'h00 : lo1 + 8'h01;
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    property p_full; $stable(FIFO_FULL_IN)[*3] ##0 (RD_IN && ADDR_IN ==
        `SLMS_OFF_FULL) |=> RDATA_OUT == $past(FIFO_FULL_IN); endproperty
    a_full: assert property (p_full) else $error("full flags");
    property p_empty; $stable(FIFO_EMPTY_IN)[*3] ##0 (RD_IN && ADDR_IN ==
        `SLMS_OFF_EMPTY) |=> RDATA_OUT == $past(FIFO_EMPTY_IN); endproperty
    a_empty: assert property (p_empty) else $error("empty flags");
    property p_req0; $rose(FRAME_LOSS_IN[0]) && en[0] ||
        $rose(MFRAME_LOSS_IN[0]) && en[2] |-> ##[1:5] !SYNC_N_0_OUT;
    endproperty
    a_req0: assert property (p_req0) else $error("no request 0");
    property p_req1; $rose(FRAME_LOSS_IN[1]) && en[1] ||
        $rose(MFRAME_LOSS_IN[1]) && en[3] |-> ##[1:5] !SYNC_N_1_OUT;
    endproperty
    a_req1: assert property (p_req1) else $error("no request 1");
    property p_len0;
        $rose(SYNC_N_0_OUT) |-> lo0 == (2*code+1)*PCLK_DIV/2; endproperty
    a_len0: assert property (p_len0) else $error("low time 0");
    property p_len1;
        $rose(SYNC_N_1_OUT) |-> lo1 == (2*code+1)*PCLK_DIV/2; endproperty
    a_len1: assert property (p_len1) else $error("low time 1");
    property p_phy; WR_IN && ADDR_IN == `SLMS_OFF_PHY_TEST |=>
        PHY_CLK_UNGATE_OUT == $past(WDATA_IN); endproperty
    a_phy: assert property (p_phy) else $error("phy enable");
    property p_hold; !(WR_IN && ADDR_IN == `SLMS_OFF_PHY_TEST) |=>
        $stable(PHY_CLK_UNGATE_OUT); endproperty
    a_hold: assert property (p_hold) else $error("phy drift");
endmodule // slms_props

// >>> verification/slms_tx_model.sv
// Transmitter model: moving lane words and loss levels
`timescale 1ns/1ps
module slms_tx_model (
    input wire clk_in,
    input wire [3:0] loss_in, // Wanted {mf1, mf0, f1, f0}
    output reg [255:0] lanes_out = 256'h0, // Lane n at [n*32+:32]
    output reg [1:0] fl_out = 2'h0, // Frame loss per decoder
    output reg [1:0] ml_out = 2'h0 // Multiframe loss per decoder
);
    integer n;
    // Words move each cycle so a stale lane shows; top byte names it
    always @(posedge clk_in) begin
        {ml_out, fl_out} <= loss_in;
        for (n = 0; n < 8; n = n + 1) begin
            lanes_out[n*32+:32] <= {4'hA, n[3:0], lanes_out[23:0] + 24'h1};
        end
    end
endmodule // slms_tx_model

// >>> verification/tb_serdes_lane_map_sync_report.sv
// Self-checking bench for the lane map and sync-request block
`timescale 1ns/1ps
`include "slms_defs.vh"
module tb_serdes_lane_map_sync_report;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [11:0] addr = 12'h000;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] full = 8'h00;
    reg [7:0] empty = 8'hFF;
    reg [3:0] loss = 4'h0;
    wire [7:0] rdata;
    wire [31:0] lane6;
    wire [1:0] sn;
    wire [7:0] phy;
    wire [255:0] lanes;
    wire [1:0] fl;
    wire [1:0] ml;
    integer miscompares = 0;
    integer checks = 0;
    integer cycles = 0;
    integer i;
    integer c;
    integer k0;
    integer k1;
    reg [7:0] m;
    initial forever #50 clk = ~clk;
    slms_tx_model slms_tx_model_inst (.clk_in(clk), .loss_in(loss),
        .lanes_out(lanes), .fl_out(fl), .ml_out(ml));
    slms_lane_map_sync slms_lane_map_sync_inst (.CLK_IN(clk),
        .RESET_IN(rst), .CE_IN(1'b1), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LANE_DATA_IN(lanes),
        .FIFO_FULL_IN(full), .FIFO_EMPTY_IN(empty), .FRAME_LOSS_IN(fl),
        .MFRAME_LOSS_IN(ml), .LANE6_DATA_OUT(lane6), .SYNC_N_0_OUT(sn[0]),
        .SYNC_N_1_OUT(sn[1]), .PHY_CLK_UNGATE_OUT(phy));
    task check(input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr_reg(input [11:0] a, input [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [11:0] a, input [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask
    task print_verdict;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`SLMS_OFF_LANE6, 8'h06);
        rd_reg(`SLMS_OFF_PHY_TEST, 8'h00);
        for (c = 0; c < 8; c = c + 1) begin
            wr_reg(`SLMS_OFF_LANE6, c[7:0]);
            repeat (2) @(negedge clk);
            check(lane6[31:24], {5'h14, c[2:0]});
        end
        $display("map done");
        @(posedge clk);
        full <= 8'h5A;
        empty <= 8'h81;
        // Two synchroniser stages before the read mux sees the pins
        repeat (2) @(posedge clk);
        rd_reg(`SLMS_OFF_FULL, 8'h5A);
        rd_reg(`SLMS_OFF_EMPTY, 8'h81);
        wr_reg(`SLMS_OFF_FULL, 8'hFF);
        full <= 8'h01;
        repeat (2) @(posedge clk);
        rd_reg(`SLMS_OFF_FULL, 8'h01);
        rd_reg(12'h000, 8'h00);
        $display("flags done");
        // Codes sweep the field; software would aim at half a frame
        for (i = 0; i < 8; i = i + 1) begin
            c = (i * 5) % 16;
            m = (i < 4) ? 8'h01 << i[1:0] : 8'h0F ^ (8'h01 << i[1:0]);
            wr_reg(`SLMS_OFF_PULSE, {c[3:0], 4'h0});
            wr_reg(`SLMS_OFF_LOSS_EN, m);
            rd_reg(`SLMS_OFF_LOSS_EN, m);
            @(posedge clk);
            loss <= 4'h1 << i[1:0];
            k0 = 0;
            k1 = 0;
            repeat (80) begin
                @(negedge clk);
                k0 = k0 + (sn[0] === 1'b0);
                k1 = k1 + (sn[1] === 1'b0);
            end
            @(posedge clk);
            loss <= 4'h0;
            k0 = i[0] ? k1 : k0;
            k1 = (i < 4) ? (2 * c + 1) * `SLMS_PCLK_DIV / 2 : 0;
            check(k0, k1);
        end
        $display("sync done");
        wr_reg(`SLMS_OFF_PHY_TEST, 8'hC3);
        @(negedge clk);
        check(phy, 8'hC3);
        rd_reg(`SLMS_OFF_PHY_TEST, 8'hC3);
        $display("phy done");
        print_verdict;
    end
endmodule // tb_serdes_lane_map_sync_report
bind slms_lane_map_sync slms_props #(.PCLK_DIV(PCLK_DIV)) slms_props_inst (
    .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .FIFO_FULL_IN(FIFO_FULL_IN),
    .FIFO_EMPTY_IN(FIFO_EMPTY_IN), .FRAME_LOSS_IN(FRAME_LOSS_IN),
    .MFRAME_LOSS_IN(MFRAME_LOSS_IN), .SYNC_N_0_OUT(SYNC_N_0_OUT),
    .SYNC_N_1_OUT(SYNC_N_1_OUT), .PHY_CLK_UNGATE_OUT(PHY_CLK_UNGATE_OUT));
